/* File: logic/pis_top.sv */
`timescale 1ns/1ps
// Function
// - Rising one-second pin edge sets one-second bit.
// - Summary read of any port clears it.
// - Enabled falling framer edge sets external bit.
// - Summary read clears external bit.
// - Summary bit 1 mirrors transmit interrupt pending.
// - Summary bit 0 mirrors receive interrupt pending.
// - Cell summary bits clear with their sources.
// - Reserved bits always read zero.
// - Device summary bit n flags port n.
// - Device summary bits clear with sources.
// - Status bit 7 records parity fault.
// - Status bit 6 records cell start fault.
// - Status bit 5 records transmit FIFO overrun.
// - Status bit 4 records receive FIFO overrun.
// - Status bit 3 records non-idle cell sent.
// - Status bit 2 records address clash.
// - Status events latch until read, then clear.
// - Enabled status rise sets interrupt; read clears.
module pis_top (
    input  wire logic                             clock_in,
    input  wire logic                             rst_in,
    input  wire logic       [9:0]                 reg_addr_in,
    input  wire logic       [7:0]                 reg_wdata_in,
    input  wire logic                             reg_wr_in,
    input  wire logic                             reg_rd_in,
    output logic            [7:0]                 reg_rdata_out,
    input  wire logic                             one_second_pulse_input_in,
    input  wire logic       [7:0]                 framer_interrupt_input_n_in,
    input  wire logic       [7:0]                 rx_cell_pending_in,
    input  wire pis_pkg::pis_tx_evt_t [7:0]       tx_evt_in,
    output logic                                  device_irq_out
);

    logic [2:0] port_sel_w;
    logic       rd_summary_w;
    logic       rd_tx_int_w;
    logic       rd_tx_status_w;
    logic       rd_device_w;
    logic       wr_int_enable_w;
    logic       wr_tx_enable_w;

    always_comb begin
        port_sel_w      = pis_pkg::pis_port(reg_addr_in);
        rd_summary_w    = reg_rd_in && pis_pkg::pis_hit(reg_addr_in, pis_pkg::OFF_SUMMARY);
        rd_tx_int_w     = reg_rd_in && pis_pkg::pis_hit(reg_addr_in, pis_pkg::OFF_TX_INT);
        rd_tx_status_w  = reg_rd_in && pis_pkg::pis_hit(reg_addr_in, pis_pkg::OFF_TX_STATUS);
        rd_device_w     = reg_rd_in && (reg_addr_in == pis_pkg::ADDR_DEVICE_SUMMARY);
        wr_int_enable_w = reg_wr_in && pis_pkg::pis_hit(reg_addr_in, pis_pkg::OFF_INT_ENABLE);
        wr_tx_enable_w  = reg_wr_in && pis_pkg::pis_hit(reg_addr_in, pis_pkg::OFF_TX_INT_ENABLE);
    end

    // One-second event: a single flag shared by all ports.
    logic one_sec_prev_r;
    logic one_sec_prev_nxt;
    logic one_sec_flag_r;
    logic one_sec_flag_nxt;
    logic one_sec_edge_w;

    always_comb begin
        one_sec_prev_nxt = one_second_pulse_input_in;
        one_sec_edge_w   = one_second_pulse_input_in & ~one_sec_prev_r;
        // The flag is common, so a summary read of any port clears it.
        one_sec_flag_nxt = (one_sec_flag_r & ~rd_summary_w) | one_sec_edge_w;
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            one_sec_prev_r <= 1'b0;
            one_sec_flag_r <= 1'b0;
        end else begin
            one_sec_prev_r <= one_sec_prev_nxt;
            one_sec_flag_r <= one_sec_flag_nxt;
        end
    end

    // Enable registers: one byte each per port.
    logic [7:0] int_enable_r     [pis_pkg::NUM_PORTS];
    logic [7:0] int_enable_nxt   [pis_pkg::NUM_PORTS];
    logic [7:0] tx_enable_r      [pis_pkg::NUM_PORTS];
    logic [7:0] tx_enable_nxt    [pis_pkg::NUM_PORTS];

    always_comb begin
        for (int p = 0; p < pis_pkg::NUM_PORTS; p++) begin
            int_enable_nxt[p] = int_enable_r[p];
            tx_enable_nxt[p]  = tx_enable_r[p];
            if (wr_int_enable_w && port_sel_w == 3'(p)) begin
                int_enable_nxt[p] = reg_wdata_in & (8'h01 << pis_pkg::SUM_EXT_BIT);
            end
            if (wr_tx_enable_w && port_sel_w == 3'(p)) begin
                tx_enable_nxt[p] = reg_wdata_in & pis_pkg::TX_USED_MASK;
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            for (int p = 0; p < pis_pkg::NUM_PORTS; p++) begin
                int_enable_r[p] <= pis_pkg::RESET_BYTE;
                tx_enable_r[p]  <= pis_pkg::RESET_BYTE;
            end
        end else begin
            for (int p = 0; p < pis_pkg::NUM_PORTS; p++) begin
                int_enable_r[p] <= int_enable_nxt[p];
                tx_enable_r[p]  <= tx_enable_nxt[p];
            end
        end
    end

    // Per-port transmit status and port summary.
    logic [7:0] tx_status_w  [pis_pkg::NUM_PORTS];
    logic [7:0] tx_int_w     [pis_pkg::NUM_PORTS];
    logic [7:0] summary_w    [pis_pkg::NUM_PORTS];
    logic [7:0] device_summary_w;

    for (genvar g = 0; g < pis_pkg::NUM_PORTS; g++) begin : g_port
        pis_transmit_cell_status u_transmit_cell_status (
            .clock_in     (clock_in),
            .rst_in       (rst_in),
            .evt_in       (tx_evt_in[g]),
            .enable_in    (tx_enable_r[g]),
            .status_rd_in (rd_tx_status_w && port_sel_w == 3'(g)),
            .int_rd_in    (rd_tx_int_w && port_sel_w == 3'(g)),
            .status_out   (tx_status_w[g]),
            .intr_out     (tx_int_w[g])
        );

        pis_port_summary u_summary (
            .clock_in        (clock_in),
            .rst_in          (rst_in),
            .framer_n_in     (framer_interrupt_input_n_in[g]),
            .ext_enable_in   (int_enable_r[g][pis_pkg::SUM_EXT_BIT]),
            .summary_rd_in   (rd_summary_w && port_sel_w == 3'(g)),
            .one_sec_flag_in (one_sec_flag_r),
            .tx_int_any_in   (tx_int_w[g] != 8'h00),
            .rx_pending_in   (rx_cell_pending_in[g]),
            .summary_out     (summary_w[g])
        );
    end

    // Device summary has no storage of its own, so it clears with its sources.
    always_comb begin
        for (int p = 0; p < pis_pkg::NUM_PORTS; p++) begin
            device_summary_w[p] = (summary_w[p] & pis_pkg::SUM_USED_MASK) != 8'h00;
        end
    end

    // Read data and interrupt output, both registered.
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       irq_r;
    logic       irq_nxt;

    always_comb begin
        rdata_nxt = pis_pkg::RESET_BYTE;
        if (rd_device_w) begin
            rdata_nxt = device_summary_w;
        end else if (reg_rd_in && !reg_addr_in[pis_pkg::REGION_BIT]) begin
            case (reg_addr_in[5:0])
                pis_pkg::OFF_SUMMARY:       rdata_nxt = summary_w[port_sel_w];
                pis_pkg::OFF_TX_INT:        rdata_nxt = tx_int_w[port_sel_w];
                pis_pkg::OFF_RX_INT:        rdata_nxt = pis_pkg::RESET_BYTE;
                pis_pkg::OFF_TX_STATUS:     rdata_nxt = tx_status_w[port_sel_w];
                pis_pkg::OFF_INT_ENABLE:    rdata_nxt = int_enable_r[port_sel_w];
                pis_pkg::OFF_TX_INT_ENABLE: rdata_nxt = tx_enable_r[port_sel_w];
                default:                    rdata_nxt = pis_pkg::RESET_BYTE;
            endcase
        end
        irq_nxt = device_summary_w != 8'h00;
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_r <= pis_pkg::RESET_BYTE;
            irq_r   <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            irq_r   <= irq_nxt;
        end
    end

    assign reg_rdata_out  = rdata_r;
    assign device_irq_out = irq_r;

    // Checks on the shared flag, the summaries and the bus answer.
    property p_one_sec_set;
        @(posedge clock_in) disable iff (rst_in)
        (one_second_pulse_input_in && !one_sec_prev_r) |=> one_sec_flag_r;
    endproperty
    a_one_sec_set: assert property (p_one_sec_set) else $error("one-second flag not set");

    property p_one_sec_clear;
        @(posedge clock_in) disable iff (rst_in)
        (rd_summary_w && !one_sec_edge_w) |=> !one_sec_flag_r;
    endproperty
    a_one_sec_clear: assert property (p_one_sec_clear) else $error("one-second flag kept");

    property p_set_wins;
        @(posedge clock_in) disable iff (rst_in)
        (rd_summary_w && one_sec_edge_w) |=> one_sec_flag_r;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to read");

    property p_tx_summary;
        @(posedge clock_in) disable iff (rst_in)
        summary_w[0][1] == (tx_int_w[0] != 8'h00);
    endproperty
    a_tx_summary: assert property (p_tx_summary) else $error("tx summary mismatch");

    property p_rx_summary;
        @(posedge clock_in) disable iff (rst_in)
        summary_w[3][0] == rx_cell_pending_in[3];
    endproperty
    a_rx_summary: assert property (p_rx_summary) else $error("rx summary mismatch");

    property p_device_read;
        @(posedge clock_in) disable iff (rst_in)
        rd_device_w |=> (reg_rdata_out == $past(device_summary_w));
    endproperty
    a_device_read: assert property (p_device_read) else $error("device summary read wrong");

    property p_summary_reserved;
        @(posedge clock_in) disable iff (rst_in)
        rd_summary_w |=> (reg_rdata_out[7:4] == 4'h0);
    endproperty
    a_summary_reserved: assert property (p_summary_reserved) else $error("reserved bits set");

    property p_irq;
        @(posedge clock_in) disable iff (rst_in)
        (device_summary_w != 8'h00) |=> device_irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt output missing");

    property p_irq_low;
        @(posedge clock_in) disable iff (rst_in)
        (device_summary_w == 8'h00) |=> !device_irq_out;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt output stuck");

    property p_one_sec_hold;
        @(posedge clock_in) disable iff (rst_in)
        (one_sec_flag_r && !rd_summary_w) |=> one_sec_flag_r;
    endproperty
    a_one_sec_hold: assert property (p_one_sec_hold) else $error("one-second flag dropped");

    property p_one_sec_quiet;
        @(posedge clock_in) disable iff (rst_in)
        (!one_sec_flag_r && !one_sec_edge_w) |=> !one_sec_flag_r;
    endproperty
    a_one_sec_quiet: assert property (p_one_sec_quiet) else $error("one-second flag set idle");

    // The shared flag must reach every port, so all device bits rise together.
    property p_one_sec_all;
        @(posedge clock_in) disable iff (rst_in)
        one_sec_flag_r |-> (device_summary_w == 8'hFF);
    endproperty
    a_one_sec_all: assert property (p_one_sec_all) else $error("one-second flag not shown");

    property p_ext_en_wr;
        @(posedge clock_in) disable iff (rst_in)
        (wr_int_enable_w && port_sel_w == 3'h2)
            |=> (int_enable_r[2] == ($past(reg_wdata_in) & 8'h04));
    endproperty
    a_ext_en_wr: assert property (p_ext_en_wr) else $error("external enable write lost");

    property p_tx_en_wr;
        @(posedge clock_in) disable iff (rst_in)
        (wr_tx_enable_w && port_sel_w == 3'h6)
            |=> (tx_enable_r[6] == ($past(reg_wdata_in) & pis_pkg::TX_USED_MASK));
    endproperty
    a_tx_en_wr: assert property (p_tx_en_wr) else $error("transmit enable write lost");

    property p_summary_read;
        @(posedge clock_in) disable iff (rst_in)
        rd_summary_w |=> (reg_rdata_out == $past(summary_w[port_sel_w]));
    endproperty
    a_summary_read: assert property (p_summary_read) else $error("summary read wrong");

    property p_tx_int_read;
        @(posedge clock_in) disable iff (rst_in)
        rd_tx_int_w |=> (reg_rdata_out == $past(tx_int_w[port_sel_w]));
    endproperty
    a_tx_int_read: assert property (p_tx_int_read) else $error("tx interrupt read wrong");

    property p_tx_status_read;
        @(posedge clock_in) disable iff (rst_in)
        rd_tx_status_w |=> (reg_rdata_out == $past(tx_status_w[port_sel_w]));
    endproperty
    a_tx_status_read: assert property (p_tx_status_read) else $error("tx status read wrong");

    property p_tx_status_rsvd;
        @(posedge clock_in) disable iff (rst_in)
        rd_tx_status_w |=> (reg_rdata_out[1:0] == 2'h0);
    endproperty
    a_tx_status_rsvd: assert property (p_tx_status_rsvd) else $error("status reserved set");

    property p_rx_hole;
        @(posedge clock_in) disable iff (rst_in)
        (reg_rd_in && pis_pkg::pis_hit(reg_addr_in, pis_pkg::OFF_RX_INT))
            |=> (reg_rdata_out == 8'h00);
    endproperty
    a_rx_hole: assert property (p_rx_hole) else $error("receive hole not zero");

    property p_rdata_idle;
        @(posedge clock_in) disable iff (rst_in)
        !reg_rd_in |=> (reg_rdata_out == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data held");

    // With the pin high there is no new fall, so the read must win.
    property p_ext_rd_clear;
        @(posedge clock_in) disable iff (rst_in)
        (rd_summary_w && port_sel_w == 3'h2 && framer_interrupt_input_n_in[2])
            |=> !summary_w[2][pis_pkg::SUM_EXT_BIT];
    endproperty
    a_ext_rd_clear: assert property (p_ext_rd_clear) else $error("external bit kept");

endmodule

/* File: logic/pis_pkg.sv */
package pis_pkg;

    localparam int NUM_PORTS     = 8;
    localparam int ADDR_W        = 10;
    localparam int DATA_W        = 8;
    localparam int PORT_SEL_LSB  = 6;
    localparam int PORT_SEL_MSB  = 8;
    localparam int REGION_BIT    = 9;

    // Per-port register offsets inside each 0x40 port window.
    localparam logic [5:0] OFF_SUMMARY       = 6'h00;
    localparam logic [5:0] OFF_TX_INT        = 6'h2C;
    localparam logic [5:0] OFF_RX_INT        = 6'h2D;
    localparam logic [5:0] OFF_TX_STATUS     = 6'h2E;
    localparam logic [5:0] OFF_INT_ENABLE    = 6'h3E;
    localparam logic [5:0] OFF_TX_INT_ENABLE = 6'h3F;

    localparam logic [9:0] ADDR_DEVICE_SUMMARY = 10'h200;

    // Port summary register fields.
    localparam int SUM_ONE_SEC_BIT = 3;
    localparam int SUM_EXT_BIT     = 2;
    localparam int SUM_TX_BIT      = 1;
    localparam int SUM_RX_BIT      = 0;
    localparam logic [7:0] SUM_USED_MASK = 8'h0F;

    // Transmit cell status and interrupt fields.
    localparam int TX_PARITY_BIT   = 7;
    localparam int TX_START_BIT    = 6;
    localparam int TX_TXOVR_BIT    = 5;
    localparam int TX_RXOVR_BIT    = 4;
    localparam int TX_SENT_BIT     = 3;
    localparam int TX_CLASH_BIT    = 2;
    localparam logic [7:0] TX_USED_MASK = 8'hFC;

    localparam logic [7:0] RESET_BYTE         = 8'h00;
    localparam logic       FRAMER_IDLE_LEVEL  = 1'b1;

    typedef struct packed {
        logic parity_fault;
        logic cell_start_fault;
        logic tx_fifo_overrun;
        logic rx_fifo_overrun;
        logic cell_transmitted;
        logic cell_idle;
        logic address_clash;
    } pis_tx_evt_t;

    function automatic logic pis_hit(input logic [9:0] addr, input logic [5:0] off);
        pis_hit = (addr[REGION_BIT] == 1'b0) && (addr[5:0] == off);
    endfunction

    function automatic logic [2:0] pis_port(input logic [9:0] addr);
        pis_port = addr[PORT_SEL_MSB:PORT_SEL_LSB];
    endfunction

endpackage

/* File: logic/pis_transmit_cell_status.sv */
`timescale 1ns/1ps
module pis_transmit_cell_status (
    input  wire logic                 clock_in,
    input  wire logic                 rst_in,
    input  wire pis_pkg::pis_tx_evt_t evt_in,
    input  wire logic [7:0]           enable_in,
    input  wire logic                 status_rd_in,
    input  wire logic                 int_rd_in,
    output logic      [7:0]           status_out,
    output logic      [7:0]           intr_out
);
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] intr_r;
    logic [7:0] intr_nxt;
    logic [7:0] ev_w;
    logic [7:0] base_s;
    logic [7:0] base_i;

    always_comb begin
        ev_w                         = pis_pkg::RESET_BYTE;
        ev_w[pis_pkg::TX_PARITY_BIT] = evt_in.parity_fault;
        ev_w[pis_pkg::TX_START_BIT]  = evt_in.cell_start_fault;
        ev_w[pis_pkg::TX_TXOVR_BIT]  = evt_in.tx_fifo_overrun;
        ev_w[pis_pkg::TX_RXOVR_BIT]  = evt_in.rx_fifo_overrun;
        ev_w[pis_pkg::TX_SENT_BIT]   = evt_in.cell_transmitted & ~evt_in.cell_idle;
        ev_w[pis_pkg::TX_CLASH_BIT]  = evt_in.address_clash;
        // An event in the read cycle survives the clear.
        base_s     = status_rd_in ? pis_pkg::RESET_BYTE : status_r;
        status_nxt = (base_s | ev_w) & pis_pkg::TX_USED_MASK;
        base_i     = int_rd_in ? pis_pkg::RESET_BYTE : intr_r;
        intr_nxt   = (base_i | (ev_w & ~base_s & enable_in)) & pis_pkg::TX_USED_MASK;
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            status_r <= pis_pkg::RESET_BYTE;
            intr_r   <= pis_pkg::RESET_BYTE;
        end else begin
            status_r <= status_nxt;
            intr_r   <= intr_nxt;
        end
    end

    assign status_out = status_r;
    assign intr_out   = intr_r;

    property p_status_latch;
        @(posedge clock_in) disable iff (rst_in)
        (ev_w != 8'h00) |=> ((status_r & $past(ev_w)) == ($past(ev_w) & 8'hFC));
    endproperty
    a_status_latch: assert property (p_status_latch) else $error("status event lost");

    property p_status_clear;
        @(posedge clock_in) disable iff (rst_in)
        (status_rd_in && ev_w == 8'h00) |=> (status_r == 8'h00);
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status not cleared on read");

    property p_idle_no_sent;
        @(posedge clock_in) disable iff (rst_in)
        (evt_in.cell_idle && !status_r[3]) |=> !status_r[3];
    endproperty
    a_idle_no_sent: assert property (p_idle_no_sent) else $error("idle cell set sent bit");

    property p_int_on_rise;
        @(posedge clock_in) disable iff (rst_in)
        (!status_r[7] && ev_w[7] && enable_in[7]) |=> intr_r[7];
    endproperty
    a_int_on_rise: assert property (p_int_on_rise) else $error("interrupt not raised");

    property p_int_clear;
        @(posedge clock_in) disable iff (rst_in)
        (int_rd_in && (ev_w & enable_in) == 8'h00) |=> (intr_r == 8'h00);
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("interrupt not cleared on read");

    property p_tx_reserved;
        @(posedge clock_in) disable iff (rst_in)
        (status_r[1:0] == 2'b00) && (intr_r[1:0] == 2'b00);
    endproperty
    a_tx_reserved: assert property (p_tx_reserved) else $error("reserved bits set");
endmodule

/* File: logic/pis_port_summary.sv */
`timescale 1ns/1ps
module pis_port_summary (
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic       framer_n_in,
    input  wire logic       ext_enable_in,
    input  wire logic       summary_rd_in,
    input  wire logic       one_sec_flag_in,
    input  wire logic       tx_int_any_in,
    input  wire logic       rx_pending_in,
    output logic [7:0]      summary_out
);
    logic framer_prev_r;
    logic framer_prev_nxt;
    logic ext_flag_r;
    logic ext_flag_nxt;
    logic fall_w;

    always_comb begin
        framer_prev_nxt = framer_n_in;
        fall_w          = framer_prev_r & ~framer_n_in;
        // New edge wins over a clearing read in the same cycle.
        ext_flag_nxt    = (ext_flag_r & ~summary_rd_in) | (fall_w & ext_enable_in);
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            framer_prev_r <= pis_pkg::FRAMER_IDLE_LEVEL;
            ext_flag_r    <= 1'b0;
        end else begin
            framer_prev_r <= framer_prev_nxt;
            ext_flag_r    <= ext_flag_nxt;
        end
    end

    always_comb begin
        summary_out                           = pis_pkg::RESET_BYTE;
        summary_out[pis_pkg::SUM_ONE_SEC_BIT] = one_sec_flag_in;
        summary_out[pis_pkg::SUM_EXT_BIT]     = ext_flag_r;
        summary_out[pis_pkg::SUM_TX_BIT]      = tx_int_any_in;
        summary_out[pis_pkg::SUM_RX_BIT]      = rx_pending_in;
    end

    property p_ext_set;
        @(posedge clock_in) disable iff (rst_in)
        (framer_prev_r && !framer_n_in && ext_enable_in) |=> ext_flag_r;
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("external flag not set");

    property p_ext_gated;
        @(posedge clock_in) disable iff (rst_in)
        (!ext_flag_r && !ext_enable_in) |=> !ext_flag_r;
    endproperty
    a_ext_gated: assert property (p_ext_gated) else $error("disabled external flag set");

    property p_ext_clear;
        @(posedge clock_in) disable iff (rst_in)
        (summary_rd_in && !(fall_w && ext_enable_in)) |=> !ext_flag_r;
    endproperty
    a_ext_clear: assert property (p_ext_clear) else $error("external flag not cleared");
endmodule

/* File: sim/pis_host.sv */
`timescale 1ns/1ps
module pis_host (
    input  wire logic       clock_in,
    input  wire logic [7:0] rdata_in,
    output logic      [9:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic            wr_out,
    output logic            rd_out
);
    // Idle cycles before each access, so the host can also act slowly.
    int gap = 0;

    initial begin
        addr_out  = 10'h000;
        wdata_out = 8'h00;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end

    task automatic write_reg(input logic [9:0] addr, input logic [7:0] data);
        repeat (gap) @(posedge clock_in);
        @(posedge clock_in);
        addr_out  <= addr;
        wdata_out <= data;
        wr_out    <= 1'b1;
        @(posedge clock_in);
        wr_out    <= 1'b0;
    endtask

    // The byte stands only in the cycle after the strobe, so it is taken at that cycle's end.
    task automatic read_reg(input logic [9:0] addr, output logic [7:0] data);
        repeat (gap) @(posedge clock_in);
        @(posedge clock_in);
        addr_out <= addr;
        rd_out   <= 1'b1;
        @(posedge clock_in);
        rd_out   <= 1'b0;
        @(posedge clock_in);
        data = rdata_in;
    endtask
endmodule

/* File: sim/test_port_interrupt_summary_status.sv */
`timescale 1ns/1ps
module test_port_interrupt_summary_status;
    logic                       clock_in;
    logic                       rst_in;
    logic [9:0]                 reg_addr;
    logic [7:0]                 reg_wdata;
    logic                       reg_wr;
    logic                       reg_rd;
    logic [7:0]                 reg_rdata;
    logic                       one_sec;
    logic [7:0]                 framer_n;
    logic [7:0]                 rx_pend;
    pis_pkg::pis_tx_evt_t [7:0] tx_evt;
    logic                       irq;
    logic [7:0]                 rd;
    int                         n_fail = 0;
    int                         cmp_count = 0;

    pis_top dut (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .one_second_pulse_input_in(one_sec),
        .framer_interrupt_input_n_in(framer_n), .rx_cell_pending_in(rx_pend),
        .tx_evt_in(tx_evt), .device_irq_out(irq));

    pis_host host (.clock_in(clock_in), .rdata_in(reg_rdata), .addr_out(reg_addr),
        .wdata_out(reg_wdata), .wr_out(reg_wr), .rd_out(reg_rd));

    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    function automatic logic [9:0] padr(input int p, input logic [5:0] off);
        padr = {1'b0, 3'(p), off};
    endfunction

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic expect_reg(input string what, input logic [9:0] a, input logic [7:0] exp);
        host.read_reg(a, rd);
        check(what, exp, rd);
    endtask

    task automatic tx_pulse(input int p, input logic [6:0] ev);
        @(posedge clock_in);
        tx_evt[p] <= pis_pkg::pis_tx_evt_t'(ev);
        @(posedge clock_in);
        tx_evt[p] <= '0;
    endtask

    task automatic t_reset();
        check("irq", 8'h00, {7'h00, irq});
        expect_reg("device summary", pis_pkg::ADDR_DEVICE_SUMMARY, 8'h00);
        expect_reg("summary", padr(0, 6'h00), 8'h00);
        expect_reg("rx int hole", padr(0, 6'h2D), 8'h00);
        $display("test reset done");
    endtask

    task automatic t_one_second();
        @(posedge clock_in);
        one_sec <= 1'b1;
        @(posedge clock_in);
        one_sec <= 1'b0;
        expect_reg("one second", padr(3, 6'h00), 8'h08);
        expect_reg("one second other", padr(5, 6'h00), 8'h00);
        fork
            host.read_reg(padr(0, 6'h00), rd);
            begin
                @(posedge clock_in);
                one_sec <= 1'b1;
            end
        join
        one_sec <= 1'b0;
        check("read before edge", 8'h00, rd);
        expect_reg("edge beats read", padr(4, 6'h00), 8'h08);
        expect_reg("one second gone", padr(4, 6'h00), 8'h00);
        $display("test one_second done");
    endtask

    task automatic t_external();
        host.write_reg(padr(2, 6'h3E), 8'h04);
        expect_reg("ext enable", padr(2, 6'h3E), 8'h04);
        @(posedge clock_in);
        framer_n[2] <= 1'b0;
        framer_n[4] <= 1'b0;
        expect_reg("device summary", pis_pkg::ADDR_DEVICE_SUMMARY, 8'h04);
        check("irq", 8'h01, {7'h00, irq});
        expect_reg("external", padr(2, 6'h00), 8'h04);
        expect_reg("external cleared", padr(2, 6'h00), 8'h00);
        expect_reg("external masked", padr(4, 6'h00), 8'h00);
        expect_reg("device summary", pis_pkg::ADDR_DEVICE_SUMMARY, 8'h00);
        framer_n <= 8'hFF;
        $display("test external done");
    endtask

    task automatic t_status();
        for (int b = 7; b >= 2; b--) begin
            tx_pulse(1, 7'h01 << ((b == 2) ? 0 : b - 1));
            expect_reg("status bit", padr(1, 6'h2E), 8'h01 << b);
            expect_reg("status cleared", padr(1, 6'h2E), 8'h00);
        end
        tx_pulse(1, 7'h06);
        expect_reg("idle cell", padr(1, 6'h2E), 8'h00);
        expect_reg("tx int masked", padr(1, 6'h2C), 8'h00);
        $display("test status done");
    endtask

    task automatic t_tx_interrupt();
        host.gap = 1;
        host.write_reg(padr(6, 6'h3F), 8'hFC);
        tx_pulse(6, 7'h40);
        expect_reg("tx summary", padr(6, 6'h00), 8'h02);
        expect_reg("tx summary kept", padr(6, 6'h00), 8'h02);
        expect_reg("device summary", pis_pkg::ADDR_DEVICE_SUMMARY, 8'h40);
        check("irq", 8'h01, {7'h00, irq});
        expect_reg("tx interrupt", padr(6, 6'h2C), 8'h80);
        expect_reg("tx summary gone", padr(6, 6'h00), 8'h00);
        expect_reg("device summary", pis_pkg::ADDR_DEVICE_SUMMARY, 8'h00);
        check("irq", 8'h00, {7'h00, irq});
        expect_reg("tx status", padr(6, 6'h2E), 8'h80);
        host.write_reg(padr(6, 6'h3F), 8'h00);
        host.gap = 0;
        $display("test tx_interrupt done");
    endtask

    task automatic t_rx();
        @(posedge clock_in);
        rx_pend[7] <= 1'b1;
        expect_reg("rx summary", padr(7, 6'h00), 8'h01);
        expect_reg("device summary", pis_pkg::ADDR_DEVICE_SUMMARY, 8'h80);
        rx_pend[7] <= 1'b0;
        expect_reg("rx summary gone", padr(7, 6'h00), 8'h00);
        $display("test rx done");
    endtask

    task automatic t_collide();
        fork
            host.read_reg(padr(1, 6'h2E), rd);
            tx_pulse(1, 7'h40);
        join
        check("read at collide", 8'h00, rd);
        expect_reg("set beats clear", padr(1, 6'h2E), 8'h80);
        expect_reg("status cleared", padr(1, 6'h2E), 8'h00);
        $display("test collide done");
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end

    initial begin
        rst_in   = 1'b1;
        one_sec  = 1'b0;
        framer_n = 8'hFF;
        rx_pend  = 8'h00;
        tx_evt   = '0;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        t_reset();
        t_one_second();
        t_external();
        t_status();
        t_tx_interrupt();
        t_rx();
        t_collide();
        give_verdict();
    end
endmodule
